// ==== design/prs_reset_sequencer.sv ====
// reset qualification, halt and start-up sequencing for the processor core
module prs_reset_sequencer
(
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     reset_standby_pin,
  input  wire logic                     core_ale,
  input  wire logic                     core_program_store_strobe,
  output logic                          core_run,
  output logic                          core_reset_load,
  output logic                          reset_done,
  output prs_pkg::prs_core_regs_s       core_reset_regs,
  output logic [prs_pkg::NUM_PORTS-1:0] port_latch_load,
  output logic [7:0]                    port_reset_value,
  output logic                          ale_out,
  output logic                          program_store_strobe,
  output logic                          ram_write_block
);
  import prs_pkg::*;

  logic             rst_s1_r;
  logic             rst_n_r;
  logic             pin_sync;
  prs_state_e       state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             halt_nxt;

  // release of the async reset through two flops
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // pin synchroniser
  prs_sync3 u_pin_sync
  (
    .core_clk (core_clk),
    .rst_n    (rst_n_r),
    .async_in (reset_standby_pin),
    .sync_out (pin_sync)
  );

  // sequencer: count highs, halt, then start-up count after fall
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= PRS_RUN;
      cnt_r   <= '0;
    end
    else
    begin
      unique case (state_r)
        PRS_RUN:
        begin
          cnt_r <= 5'h01;
          if (pin_sync)
            state_r <= PRS_QUALIFY;
        end
        PRS_QUALIFY:
        begin
          if (!pin_sync)
            state_r <= PRS_RUN;
          else if (cnt_r == QUALIFY_CNT - 5'h01)
            state_r <= PRS_HALT;
          else
            cnt_r <= cnt_r + 5'h01;
        end
        PRS_HALT:
        begin
          cnt_r <= '0;
          if (!pin_sync)
            state_r <= PRS_STARTUP;
        end
        PRS_STARTUP:
        begin
          if (pin_sync)
          begin
            state_r <= PRS_QUALIFY;
            cnt_r   <= 5'h01;
          end
          else if (cnt_r == STARTUP_CNT - 5'h01)
            state_r <= PRS_RUN;
          else
            cnt_r <= cnt_r + 5'h01;
        end
        default:
          state_r <= PRS_RUN;
      endcase
    end
  end

  assign halt_nxt = (state_r == PRS_HALT) || (state_r == PRS_STARTUP);

  // execution gate and reset loading; strobes forced high while halted
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      core_run             <= 1'b0;
      core_reset_load      <= 1'b1;
      reset_done           <= 1'b0;
      ale_out              <= 1'b1;
      program_store_strobe <= 1'b1;
      ram_write_block      <= 1'b1;
    end
    else
    begin
      core_run             <= !halt_nxt;
      core_reset_load      <= halt_nxt;
      reset_done           <= (state_r == PRS_STARTUP) && !pin_sync
                              && (cnt_r == STARTUP_CNT - 5'h01);
      ale_out              <= halt_nxt ? 1'b1 : core_ale;
      program_store_strobe <= halt_nxt ? 1'b1 : core_program_store_strobe;
      ram_write_block      <= halt_nxt;
    end
  end

  // reset image and port reset value, held constant from registers; port latch load follows halt_nxt
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      core_reset_regs.program_counter        <= PROG_CNT_RESET; // image loaded while reset is asserted, valid before the first edge
      core_reset_regs.stack_pointer          <= STACK_RESET;
      core_reset_regs.accumulator            <= ZERO_RESET;
      core_reset_regs.b_reg                  <= ZERO_RESET;
      core_reset_regs.status_word            <= ZERO_RESET;
      core_reset_regs.data_pointer           <= {ZERO_RESET, ZERO_RESET};
      core_reset_regs.timer_control_reg      <= ZERO_RESET;
      core_reset_regs.timer_mode_reg         <= ZERO_RESET;
      core_reset_regs.timer0                 <= {ZERO_RESET, ZERO_RESET};
      core_reset_regs.timer1                 <= {ZERO_RESET, ZERO_RESET};
      core_reset_regs.serial_control_reg     <= ZERO_RESET;
      core_reset_regs.interrupt_priority_reg <= IPRIO_RESET;
      core_reset_regs.interrupt_enable_reg   <= IEN_RESET;
      port_latch_load                        <= '1;
      port_reset_value                       <= PORT_RESET;
    end
    else
    begin
      core_reset_regs.program_counter        <= PROG_CNT_RESET;
      core_reset_regs.stack_pointer          <= STACK_RESET;
      core_reset_regs.accumulator            <= ZERO_RESET;
      core_reset_regs.b_reg                  <= ZERO_RESET;
      core_reset_regs.status_word            <= ZERO_RESET;
      core_reset_regs.data_pointer           <= {ZERO_RESET, ZERO_RESET};
      core_reset_regs.timer_control_reg      <= ZERO_RESET;
      core_reset_regs.timer_mode_reg         <= ZERO_RESET;
      core_reset_regs.timer0                 <= {ZERO_RESET, ZERO_RESET};
      core_reset_regs.timer1                 <= {ZERO_RESET, ZERO_RESET};
      core_reset_regs.serial_control_reg     <= ZERO_RESET;
      core_reset_regs.interrupt_priority_reg <= IPRIO_RESET;
      core_reset_regs.interrupt_enable_reg   <= IEN_RESET;
      port_latch_load                        <= {NUM_PORTS{halt_nxt}};
      port_reset_value                       <= PORT_RESET;
    end
  end

  // assertions
  // pin seen low in halt, start-up entered next
  sequence pin_low_then_startup_s;
    (state_r == PRS_HALT) ##1 (state_r == PRS_STARTUP);
  endsequence

  // last qualification cycle with the pin still high
  sequence qualify_end_s;
    (state_r == PRS_QUALIFY) && pin_sync && (cnt_r == QUALIFY_CNT - 5'h01);
  endsequence

  halt_after_qual_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    qualify_end_s |=> (state_r == PRS_HALT))
    else $error("qualified high did not halt");
  short_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_QUALIFY && !pin_sync) |=> (state_r == PRS_RUN))
    else $error("short pulse not ignored");
  qual_length_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    $rose(state_r == PRS_HALT) |-> ($past(pin_sync, 23) && $past(pin_sync, 24)))
    else $error("halt without long enough high");
  startup_len_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    pin_low_then_startup_s ##0 (!pin_sync) [*8] ##1 (!pin_sync) [*4] |=> reset_done)
    else $error("startup sequence length wrong");
  strobes_high_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_HALT) |=> (ale_out && program_store_strobe))
    else $error("strobe low while halted");
  run_stops_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_HALT) |=> !core_run)
    else $error("core runs while halted");
  halt_holds_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_HALT && pin_sync) |=> (state_r == PRS_HALT))
    else $error("halt left while pin high");
  regs_value_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    core_reset_load |-> (core_reset_regs.stack_pointer == STACK_RESET
      && core_reset_regs.interrupt_enable_reg == IEN_RESET && core_reset_regs.program_counter == PROG_CNT_RESET))
    else $error("reset image wrong");
  load_in_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_HALT || state_r == PRS_STARTUP) |=> core_reset_load)
    else $error("reset image not applied");
  ports_ones_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_HALT) |=> (&port_latch_load && port_reset_value == PORT_RESET))
    else $error("ports not loaded with ones");
  ram_kept_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_HALT || state_r == PRS_STARTUP) |=> ram_write_block)
    else $error("ram writable during reset");
  resume_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    reset_done |-> ##1 core_run)
    else $error("no resume after startup");
  done_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    reset_done |=> !reset_done)
    else $error("start-up end pulse too long");
  strobe_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_RUN) |=> (ale_out == $past(core_ale)
      && program_store_strobe == $past(core_program_store_strobe)))
    else $error("strobes not passed while running");
  qual_keeps_run_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    (state_r == PRS_QUALIFY) |=> core_run)
    else $error("core stopped before qualification");
endmodule

// ==== design/prs_pkg.sv ====
// package for the processor reset sequencer: widths, counts and reset values
package prs_pkg;
  // oscillator periods map one to one onto core_clk cycles
  localparam int          QUALIFY_PERIODS = 24;
  localparam int          STARTUP_PERIODS = 12;
  localparam int          CNT_W           = 5;
  localparam logic [4:0]  QUALIFY_CNT     = 5'h18;
  localparam logic [4:0]  STARTUP_CNT     = 5'h0c;
  localparam logic [15:0] PROG_CNT_RESET  = 16'h0000;
  localparam logic [7:0]  STACK_RESET     = 8'h07;
  localparam logic [7:0]  ZERO_RESET      = 8'h00;
  localparam logic [7:0]  IPRIO_RESET     = 8'he0;
  localparam logic [7:0]  IEN_RESET       = 8'h60;
  localparam logic [7:0]  PORT_RESET      = 8'hff;
  localparam int          NUM_PORTS       = 4;

  // sequencer states, one-hot
  typedef enum logic [3:0]
  {
    PRS_RUN     = 4'b0001,
    PRS_QUALIFY = 4'b0010,
    PRS_HALT    = 4'b0100,
    PRS_STARTUP = 4'b1000
  } prs_state_e;

  // reset image of the core registers
  typedef struct packed
  {
    logic [15:0] program_counter;
    logic [7:0]  stack_pointer;
    logic [7:0]  accumulator;
    logic [7:0]  b_reg;
    logic [7:0]  status_word;
    logic [15:0] data_pointer;
    logic [7:0]  timer_control_reg;
    logic [7:0]  timer_mode_reg;
    logic [15:0] timer0;
    logic [15:0] timer1;
    logic [7:0]  serial_control_reg;
    logic [7:0]  interrupt_priority_reg;
    logic [7:0]  interrupt_enable_reg;
  } prs_core_regs_s;
endpackage

// ==== design/prs_sync3.sv ====
// three-flop synchroniser with second/third agreement filter
module prs_sync3
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // shift chain; first flop feeds only the second
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // output changes only when the last two stages agree
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_out <= 1'b0;
    else if (s2_r == s3_r)
      sync_out <= s3_r;
  end
endmodule

// ==== testbench/prs_reset_source.sv ====
// model of the external reset circuit driving the reset/standby pin
module prs_reset_source
(
  input  wire logic       core_clk,
  input  wire logic       start,
  input  wire logic [7:0] hold_len,
  output logic            reset_standby_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_r = 8'h00;

  // hold the pin high for hold_len oscillator periods, then low
  always @(negedge core_clk)
  begin
    if (start)
    begin
      reset_standby_pin <= 1'b1;
      left_r            <= hold_len;
    end
    else if (left_r > 8'h01)
      left_r <= left_r - 8'h01;
    else
    begin
      left_r            <= 8'h00;
      reset_standby_pin <= 1'b0;
    end
  end

  initial reset_standby_pin = 1'b0;
endmodule

// ==== testbench/prs_reset_sequencer_bench.sv ====
// self-checking bench for the processor reset sequencer
module prs_reset_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import prs_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, core_ale = 1'b0, core_pss = 1'b0, start = 1'b0, look = 1'b0, pin;
  logic core_run, core_reset_load, reset_done, ale_out, program_store_strobe, ram_write_block;
  logic [3:0] port_latch_load;
  logic [7:0] port_reset_value, hold_len = 8'h00;
  logic [31:0] rnd = 32'hf0783595;
  logic [8:0] notes[$];
  prs_core_regs_s regs;
  int bad_count = 0, checked = 0, waited, t;

  always #20 core_clk = ~core_clk;

  prs_reset_source u_prs_reset_source (.core_clk(core_clk), .start(start), .hold_len(hold_len),
    .reset_standby_pin(pin));
  prs_reset_sequencer u_prs_reset_sequencer (.core_clk(core_clk), .reset_n(reset_n),
    .reset_standby_pin(pin), .core_ale(core_ale), .core_program_store_strobe(core_pss),
    .core_run(core_run), .core_reset_load(core_reset_load), .reset_done(reset_done),
    .core_reset_regs(regs), .port_latch_load(port_latch_load), .port_reset_value(port_reset_value),
    .ale_out(ale_out), .program_store_strobe(program_store_strobe), .ram_write_block(ram_write_block));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [135:0] seen, input logic [135:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // note the expected output vector; the monitor compares it one cycle on
  task automatic note(input logic [8:0] e);
    rnd = lfsr(rnd);
    core_ale <= rnd[0];
    core_pss <= rnd[1];
    notes.push_back(e[8] ? {1'b1, rnd[0], rnd[1], 6'h00} : e);
    look <= 1'b1;
    @(negedge core_clk);
    look <= 1'b0;
    @(negedge core_clk);
  endtask

  // bounded wait: 0 core_run low, 1 reset_done pulse, 2 core_run high
  task automatic wait_for(input int sel, input int max);
    waited = 0;
    while (!((sel == 0 && core_run === 1'b0) || (sel == 1 && reset_done === 1'b1) ||
             (sel == 2 && core_run === 1'b1)))
    begin
      @(negedge core_clk);
      waited++;
      if (waited > max)
      begin
        bad_count++;
        end_of_test();
      end
    end
  endtask

  task automatic pulse(input logic [7:0] len);
    hold_len <= len;
    start    <= 1'b1;
    @(negedge core_clk);
    start <= 1'b0;
  endtask

  // monitor: compare outputs against the oldest note
  always @(negedge core_clk)
    if (look)
      check({core_run, ale_out, program_store_strobe, ram_write_block, core_reset_load, port_latch_load},
            notes.pop_front());

  // main sequence
  initial
  begin
    repeat (5) @(negedge core_clk);
    reset_n <= 1'b1;
    wait_for(2, 10);
    check(regs, {PROG_CNT_RESET, STACK_RESET, {12{ZERO_RESET}}, IPRIO_RESET, IEN_RESET});
    check(port_reset_value, 8'hff);
    repeat (4) note(9'h100);
    // random short pulses, then one a single period short of qualifying
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      pulse(i == 3 ? 8'd23 : 8'h04 + {4'h0, rnd[3:0]});
      repeat (14) note(9'h100);
    end
    for (int k = 0; k < 2; k++)
    begin
      pulse(k == 0 ? 8'd24 : 8'd40);
      wait_for(0, 40);
      t = waited;
      note(9'h0ff);
      wait_for(1, 80);
      t = t + waited + 3;
      check((t >= (k == 0 ? 36 : 52)) && (t <= (k == 0 ? 46 : 62)), 1'b1);
      wait_for(2, 2);
      repeat (4) note(9'h100);
    end
    end_of_test();
  end
endmodule
